// [intc_pkg.sv]
/*
  Shared constants, types and helpers for the processor interrupt end
  and the cascaded slave controller end.
  Assumes both ends run on one 25 MHz clock with one active-low reset.
*/
package intc_pkg;

  localparam int          LINES        = 8;
  localparam int          ADDR_W       = 20;
  localparam logic [7:0]  CMD_PORT     = 8'hc0;
  localparam logic [7:0]  DONE_CMD     = 8'h20;
  // Vector number whose scaled address is the fixed location 00008
  localparam logic [7:0]  NMI_VECTOR   = 8'h02;
  localparam logic [1:0]  VEC_SCALE    = 2'h0;
  localparam logic [9:0]  ADDR_PAD     = 10'h000;
  localparam logic [4:0]  DIRECT_PAD   = 5'h00;
  localparam logic [1:0]  SLAVE_PAD    = 2'h0;
  localparam logic [7:0]  ALL_LINES    = 8'hff;
  localparam logic [7:0]  NO_LINES     = 8'h00;
  localparam logic [7:0]  ONE_LINE     = 8'h01;
  localparam logic [2:0]  ID_RESET     = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACK1 = 3'b001,
    ST_GAP  = 3'b011,
    ST_ACK2 = 3'b010,
    ST_READ = 3'b110,
    ST_PUSH = 3'b111,
    ST_CALL = 3'b101
  } cpu_state_type;

  // Lowest set index is highest priority; an empty vector gives line 7
  function automatic logic [2:0] lowest_index(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h7;
    for (int i = LINES - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : lowest_index

  // Lines strictly above the highest-priority line in service
  function automatic logic [7:0] above_service(input logic [7:0] isr);
    logic [7:0] low;
    low = isr & (~isr + ONE_LINE);
    return (isr == NO_LINES) ? ALL_LINES : (low - ONE_LINE);
  endfunction : above_service

endpackage : intc_pkg

// [intc_link_if.sv]
/*
  Link between the processor/master end and a cascaded slave end:
  acknowledge, cascade code, shared vector data bus and command port.
  Assumes one slave end is attached; the bus is resolved from enables.
*/
`timescale 1ns/10ps
`default_nettype none
interface intc_link_if;
  import intc_pkg::*;

  logic       inta;
  logic [2:0] cascade_code;
  logic       cascade_valid;
  logic [7:0] master_data;
  logic       master_oe;
  logic [7:0] slave_data;
  logic       slave_oe;
  logic [7:0] data_bus;
  logic       cascade_req;
  logic       cmd_wr;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_data;

  // Undriven bus reads as zero instead of floating
  assign data_bus = slave_oe ? slave_data : (master_oe ? master_data : NO_LINES);

  modport cpu_end (
    output inta,
    output cascade_code,
    output cascade_valid,
    output master_data,
    output master_oe,
    input  data_bus,
    input  cascade_req,
    input  cmd_wr,
    input  cmd_addr,
    input  cmd_data
  );

  modport slave_end (
    input  inta,
    input  cascade_code,
    input  cascade_valid,
    output slave_data,
    output slave_oe,
    output cascade_req,
    output cmd_wr,
    output cmd_addr,
    output cmd_data
  );

endinterface : intc_link_if
`default_nettype wire

// [cascade_slave_end.sv]
/*
  Cascaded slave controller with its command writer.
  Assumes the processor end pulses inta twice per acknowledge and holds
  cascade_code/cascade_valid from the cycle after the first pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module cascade_slave_end (
  input  wire logic       clk,
  input  wire logic       resetn,
  intc_link_if.slave_end  link,
  input  wire logic [7:0] req_in,
  input  wire logic [2:0] master_line,
  input  wire logic       init_wr,
  input  wire logic [2:0] init_word_two,
  input  wire logic       service_done_req,
  output logic [7:0]      in_service
);
  import intc_pkg::*;

  typedef struct packed {
    logic       second;
    logic [2:0] level;
    logic [2:0] id;
    logic [7:0] isr;
    logic [7:0] data;
    logic       oe;
    logic       cmd_wr;
    logic [7:0] cmd_addr;
    logic [7:0] cmd_data;
  } slave_state_type;

  slave_state_type s;
  slave_state_type next_s;
  logic [7:0]      pending;
  logic            chosen;

  assign pending = req_in & above_service(s.isr);
  assign link.cascade_req = |pending;
  assign chosen           = link.cascade_valid && (link.cascade_code == master_line);

  always_comb begin
    next_s        = s;
    next_s.oe     = 1'b0;
    next_s.cmd_wr = 1'b0;
    if (init_wr) begin
      next_s.id = init_word_two;
    end
    if (service_done_req) begin
      next_s.cmd_wr   = 1'b1;
      next_s.cmd_addr = CMD_PORT;
      next_s.cmd_data = DONE_CMD;
      next_s.isr      = s.isr & ~(s.isr & (~s.isr + ONE_LINE));
    end
    if (link.inta) begin
      next_s.second = ~s.second;
      if (!s.second) begin
        next_s.level = lowest_index(pending);
      end else if (chosen) begin
        next_s.oe = 1'b1;
        // id in 5:3, level in 2:0
        next_s.data = {SLAVE_PAD, s.id, s.level};
        // Set after clear so a same-cycle command cannot lose it
        next_s.isr = next_s.isr | (ONE_LINE << s.level);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{second: 1'b0, level: ID_RESET, id: ID_RESET, isr: NO_LINES, data: NO_LINES,
             oe: 1'b0, cmd_wr: 1'b0, cmd_addr: NO_LINES, cmd_data: NO_LINES};
    end else begin
      s <= next_s;
    end
  end

  assign link.slave_data = s.data;
  assign link.slave_oe   = s.oe;
  assign link.cmd_wr     = s.cmd_wr;
  assign link.cmd_addr   = s.cmd_addr;
  assign link.cmd_data   = s.cmd_data;
  assign in_service      = s.isr;

endmodule : cascade_slave_end
`default_nettype wire

// [cpu_master_intc.sv]
/*
  Processor interrupt sequencer together with the on-board master
  interrupt controller: request priority, two-pulse acknowledge,
  vector capture and the scaled indirect call.
  Assumes instruction boundaries and flag restores come from the
  surrounding core as one-cycle pulses in the same clock domain.
*/
// Operation
// - NMI serviced ahead of maskable request
// - NMI rising edge, taken at boundary
// - NMI pushes flags, clears IF, calls 00008
// - maskable request level-high, needs IF set
// - two acknowledges, vector byte on second
// - maskable entry pushes flags, clears IF
// - call address is identifier times four
// - routine end restores saved flags
// - master answers only for direct lines
// - eight lines, direct vector is line number
// - slave identifier set by init word two
// - slave raises master line, master raises request
// - first acknowledge drives cascade code
// - end command 20H at port 0C0H
`timescale 1ns/10ps
`default_nettype none
module cpu_master_intc (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  intc_link_if.cpu_end               link,
  input  wire logic                  nmi,
  input  wire logic [7:0]            request_input,
  input  wire logic [7:0]            cascade_enable,
  input  wire logic                  instr_boundary,
  input  wire logic                  if_set,
  input  wire logic                  flags_restore,
  input  wire logic                  restored_if,
  output logic                       maskable_irq_in,
  output logic                       if_flag,
  output logic                       flags_push,
  output logic                       pushed_if,
  output logic                       call_valid,
  output logic [intc_pkg::ADDR_W-1:0] call_addr,
  output logic [7:0]                 in_service
);
  import intc_pkg::*;

  typedef struct packed {
    cpu_state_type     st;
    logic              nmi_prev;
    logic              nmi_pend;
    logic              if_flag;
    logic [7:0]        isr;
    logic [2:0]        level;
    logic              cascaded;
    logic [7:0]        vector;
    logic [7:0]        mdata;
    logic              moe;
    logic [2:0]        code;
    logic              code_valid;
    logic              push;
    logic              pushed_if;
    logic              call;
    logic [ADDR_W-1:0] addr;
  } cpu_state_pack_type;

  // Power-up image: idle, interrupts disabled, nothing in service
  localparam cpu_state_pack_type RESET_STATE = '{
    st:         ST_IDLE,
    nmi_prev:   1'b0,
    nmi_pend:   1'b0,
    if_flag:    1'b0,
    isr:        NO_LINES,
    level:      ID_RESET,
    cascaded:   1'b0,
    vector:     NO_LINES,
    mdata:      NO_LINES,
    moe:        1'b0,
    code:       ID_RESET,
    code_valid: 1'b0,
    push:       1'b0,
    pushed_if:  1'b0,
    call:       1'b0,
    addr:       '0
  };

  cpu_state_pack_type s;
  cpu_state_pack_type next_s;
  logic [7:0]         irr;
  logic [7:0]         eligible;
  logic               done_hit;
  logic [2:0]         top_line;
  logic               top_cascaded;
  logic [7:0]         isr_set;
  logic [7:0]         isr_clr;

  // eight lines, slaved ones from cascade
  assign irr      = (request_input & ~cascade_enable) | ({LINES{link.cascade_req}} & cascade_enable);
  assign eligible = irr & above_service(s.isr);
  // any eligible line raises the request
  assign maskable_irq_in = |eligible;
  assign done_hit = link.cmd_wr && (link.cmd_addr == CMD_PORT) && (link.cmd_data == DONE_CMD);
  // Highest-priority eligible line and its routing
  assign top_line     = lowest_index(eligible);
  assign top_cascaded = cascade_enable[top_line];

  always_comb begin
    next_s          = s;
    next_s.nmi_prev = nmi;
    next_s.push     = 1'b0;
    next_s.call     = 1'b0;
    isr_set         = NO_LINES;
    isr_clr         = done_hit ? (s.isr & (~s.isr + ONE_LINE)) : NO_LINES;
    // Restore outranks set on the return path
    // flags restored at routine end
    if (flags_restore) begin
      next_s.if_flag = restored_if;
    end else if (if_set) begin
      next_s.if_flag = 1'b1;
    end
    case (s.st)
      ST_IDLE: begin
        if (instr_boundary && s.nmi_pend) begin
          next_s.nmi_pend = 1'b0;
          next_s.vector   = NMI_VECTOR;
          next_s.st       = ST_PUSH;
        end else if (instr_boundary && maskable_irq_in && s.if_flag) begin
          next_s.st = ST_ACK1;
        end
      end
      ST_ACK1: begin
        // A request that dropped away still completes, on line 7
        next_s.level    = top_line;
        next_s.cascaded = top_cascaded;
        isr_set         = ONE_LINE << top_line;
        next_s.code       = top_line;
        next_s.code_valid = top_cascaded;
        next_s.st         = ST_GAP;
      end
      ST_GAP: begin
        next_s.st = ST_ACK2;
      end
      ST_ACK2: begin
        // Cascaded line: bus left to the selected slave
        // master drives only direct lines
        if (!s.cascaded) begin
          next_s.mdata = {DIRECT_PAD, s.level};
          next_s.moe   = 1'b1;
        end
        next_s.st = ST_READ;
      end
      ST_READ: begin
        // vector byte taken after second pulse
        next_s.vector     = link.data_bus;
        next_s.moe        = 1'b0;
        next_s.code_valid = 1'b0;
        next_s.st         = ST_PUSH;
      end
      ST_PUSH: begin
        next_s.push      = 1'b1;
        next_s.pushed_if = s.if_flag;
        next_s.if_flag   = 1'b0;
        next_s.st        = ST_CALL;
      end
      ST_CALL: begin
        // indirect call through four times X
        next_s.call = 1'b1;
        next_s.addr = {ADDR_PAD, s.vector, VEC_SCALE};
        next_s.st   = ST_IDLE;
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
    // rising edge latched, set beats the take
    if (nmi && !s.nmi_prev) begin
      next_s.nmi_pend = 1'b1;
    end
    // Set wins over an end command in the same cycle
    next_s.isr = (s.isr & ~isr_clr) | isr_set;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // acknowledge pulses are the two ack states
  assign link.inta          = (s.st == ST_ACK1) || (s.st == ST_ACK2);
  assign link.cascade_code  = s.code;
  assign link.cascade_valid = s.code_valid;
  assign link.master_data   = s.mdata;
  assign link.master_oe     = s.moe;
  assign if_flag            = s.if_flag;
  assign flags_push         = s.push;
  assign pushed_if          = s.pushed_if;
  assign call_valid         = s.call;
  assign call_addr          = s.addr;
  assign in_service         = s.isr;

endmodule : cpu_master_intc
`default_nettype wire

// [intc_link_monitor.sv]
/*
  Link checker for the acknowledge, vector bus and command port.
  Assumes it watches the one interface that joins both design ends.
*/
`timescale 1ns/10ps
`default_nettype none
module intc_link_monitor
  import intc_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       inta,
  input wire logic       cascade_valid,
  input wire logic       master_oe,
  input wire logic       slave_oe,
  input wire logic [7:0] data_bus,
  input wire logic       cmd_wr,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_data
);
  import intc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ack_pair;
    inta && !$past(inta, 2) |=> !inta ##1 inta;
  endproperty
  property p_ack_width;
    inta |=> !inta;
  endproperty
  property p_vector_on_second;
    inta ##1 !inta ##1 inta |=> master_oe || slave_oe;
  endproperty
  property p_drive_after_ack;
    master_oe || slave_oe |-> $past(inta) && $past(inta, 3);
  endproperty
  property p_one_driver;
    (master_oe || slave_oe) |-> !(master_oe && slave_oe) ##1 !(master_oe || slave_oe);
  endproperty
  property p_slave_selected;
    slave_oe |-> $past(cascade_valid);
  endproperty
  property p_slave_byte;
    slave_oe |-> data_bus[7:6] == SLAVE_PAD;
  endproperty
  property p_direct_byte;
    master_oe |-> data_bus[7:3] == DIRECT_PAD;
  endproperty
  property p_end_command;
    cmd_wr |-> cmd_addr == CMD_PORT && cmd_data == DONE_CMD ##1 !cmd_wr;
  endproperty
  a_ack_pair : assert property (p_ack_pair) else $error("second acknowledge missing");
  a_ack_width : assert property (p_ack_width) else $error("acknowledge longer than one cycle");
  a_vector_on_second : assert property (p_vector_on_second) else $error("no vector after acknowledge");
  a_drive_after_ack : assert property (p_drive_after_ack) else $error("vector driven unasked");
  a_one_driver : assert property (p_one_driver) else $error("both ends drive vector");
  a_slave_selected : assert property (p_slave_selected) else $error("slave answered without code");
  a_slave_byte : assert property (p_slave_byte) else $error("slave byte upper bits set");
  a_direct_byte : assert property (p_direct_byte) else $error("direct byte upper bits set");
  a_end_command : assert property (p_end_command) else $error("bad end command");
  c_slave : cover property (slave_oe);
  c_master : cover property (master_oe);
  c_cmd : cover property (cmd_wr);
endmodule : intc_link_monitor
`default_nettype wire

// [tb_cascaded_interrupt_vectoring.sv]
/*
  Testbench joining the processor/master end to a slave end.
  Assumes the package constants and the designer's hand-over timing.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_cascaded_interrupt_vectoring;
  import intc_pkg::*;
  logic              clk, resetn, nmi, instr_boundary, if_set, flags_restore, restored_if;
  logic              init_wr, service_done_req, maskable_irq_in, if_flag, flags_push, pushed_if, call_valid;
  logic [7:0]        request_input, cascade_enable, req_in, in_service, slave_isr;
  logic [2:0]        master_line, init_word_two, id, lvl;
  logic [ADDR_W-1:0] call_addr;
  logic [ADDR_W-1:0] exp_q[$];
  logic [15:0]       lfsr = 16'h960a;
  int                err_count = 0;
  int                n_checks = 0;
  logic              push_seen = 1'b0;
  intc_link_if intc_link_if_inst ();
  cpu_master_intc cpu_master_intc_inst (.clk(clk), .resetn(resetn), .link(intc_link_if_inst), .nmi(nmi),
    .request_input(request_input), .cascade_enable(cascade_enable), .instr_boundary(instr_boundary),
    .if_set(if_set), .flags_restore(flags_restore), .restored_if(restored_if),
    .maskable_irq_in(maskable_irq_in), .if_flag(if_flag), .flags_push(flags_push), .pushed_if(pushed_if),
    .call_valid(call_valid), .call_addr(call_addr), .in_service(in_service));
  cascade_slave_end cascade_slave_end_inst (.clk(clk), .resetn(resetn), .link(intc_link_if_inst),
    .req_in(req_in), .master_line(master_line), .init_wr(init_wr), .init_word_two(init_word_two),
    .service_done_req(service_done_req), .in_service(slave_isr));
  intc_link_monitor intc_link_monitor_inst (.clk(clk), .resetn(resetn), .inta(intc_link_if_inst.inta),
    .cascade_valid(intc_link_if_inst.cascade_valid), .master_oe(intc_link_if_inst.master_oe),
    .slave_oe(intc_link_if_inst.slave_oe), .data_bus(intc_link_if_inst.data_bus),
    .cmd_wr(intc_link_if_inst.cmd_wr), .cmd_addr(intc_link_if_inst.cmd_addr),
    .cmd_data(intc_link_if_inst.cmd_data));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic chk_addr(input string what, input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_addr
  task automatic chk_flag(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_flag
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse
  // Bounded wait until every noted call has been seen
  task automatic wait_q();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 64) begin
      @(posedge clk);
      n++;
    end
    if (exp_q.size() != 0) begin
      err_count++;
      $display("mismatch call_valid expected %h seen none", exp_q[0]);
      exp_q.delete();
    end
    #1;
  endtask : wait_q
  task automatic finish_service();
    request_input = NO_LINES;
    req_in = NO_LINES;
    pulse(service_done_req);
    step(3);
    chk_flag("in_service", NO_LINES, in_service);
    chk_flag("slave_isr", NO_LINES, slave_isr);
  endtask : finish_service
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Calls that nobody noted count as mismatches
  always @(negedge clk) begin
    if (call_valid === 1'b1) begin
      chk_flag("flags_push", 8'h01, {7'h00, push_seen});
      if (exp_q.size() == 0) begin
        err_count++;
        $display("mismatch call_addr expected none seen %h", call_addr);
      end else begin
        chk_addr("call_addr", exp_q.pop_front(), call_addr);
      end
    end
    push_seen = (flags_push === 1'b1);
  end
  initial begin
    #(40 * 5000);
    err_count++;
    $display("mismatch watchdog expected done seen hang");
    conclude();
  end
  initial begin
    {nmi, instr_boundary, if_set, flags_restore, restored_if, init_wr, service_done_req} = '0;
    {request_input, cascade_enable, req_in} = '0;
    master_line = 3'h3;
    init_word_two = ID_RESET;
    resetn = 1'b0;
    step(16);
    resetn = 1'b1;
    chk_flag("reset", NO_LINES, {6'h00, if_flag, pushed_if} | in_service);
    instr_boundary = 1'b1;
    for (int i = 0; i < LINES; i++) begin
      request_input = ONE_LINE << i;
      step(10);
      chk_flag("maskable_irq_in", 8'h01, {7'h00, maskable_irq_in});
      exp_q.push_back({ADDR_PAD, 8'(i), VEC_SCALE});
      pulse(if_set);
      wait_q();
      chk_flag("flags", 8'h01, {6'h00, if_flag, pushed_if});
      chk_flag("in_service", ONE_LINE << i, in_service);
      finish_service();
    end
    $display("test direct done");
    cascade_enable = 8'h08;
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      {lvl, id} = lfsr[5:0];
      init_word_two = id;
      req_in = ONE_LINE << lvl;
      pulse(init_wr);
      chk_flag("maskable_irq_in", 8'h01, {7'h00, maskable_irq_in});
      exp_q.push_back({ADDR_PAD, SLAVE_PAD, id, lvl, VEC_SCALE});
      pulse(if_set);
      wait_q();
      finish_service();
    end
    $display("test cascade done");
    cascade_enable = NO_LINES;
    instr_boundary = 1'b0;
    request_input = 8'h20;
    pulse(if_set);
    nmi = 1'b1;
    step(2);
    exp_q.push_back(20'h00008);
    instr_boundary = 1'b1;
    wait_q();
    chk_flag("if_flag", NO_LINES, {7'h00, if_flag});
    // Held level must not retrigger, cleared flag must block
    step(10);
    exp_q.push_back({ADDR_PAD, 8'h05, VEC_SCALE});
    restored_if = 1'b1;
    pulse(flags_restore);
    wait_q();
    nmi = 1'b0;
    finish_service();
    $display("test nmi done");
    conclude();
  end
endmodule : tb_cascaded_interrupt_vectoring
`default_nettype wire
